// file: core/tcp_regs.svh
// constants of the three-wire configuration and readback port
// assumes inclusion by bare name from core files only
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// ************************************************************
// shift register and latches
// ************************************************************
`define TCP_SR_W        32
`define TCP_NUM_LATCH   16
`define TCP_SEL_W       4
`define TCP_LATCH_RST   32'h00000000

// ************************************************************
// readback latch fields
// ************************************************************
`define TCP_RB_LATCH    4'h7
`define TCP_RB_EN_BIT   8
`define TCP_RB_MODE_LSB 4
`define TCP_RB_MODE_MSB 7

// ************************************************************
// readback word and timing
// ************************************************************
`define TCP_RB_W        16
`define TCP_RB_BITS     5'h10
`define TCP_RB_CYCLES   18

`endif

// file: core/tcp_pkg.sv
// types of the three-wire configuration and readback port
// assumes tcp_regs.svh constants are used alongside
package tcp_pkg;

	// ************************************************************
	// readback source selection
	// ************************************************************
	typedef enum logic [3:0]
	{
		TCP_RB_AFC     = 4'h0,
		TCP_RB_RSSI    = 4'h1,
		TCP_RB_BATTERY = 4'h2,
		TCP_RB_TEMP    = 4'h3,
		TCP_RB_ADCIN   = 4'h4,
		TCP_RB_REV     = 4'h5,
		TCP_RB_FILTCAL = 4'h6
	} tcp_rb_mode_t;

	// ************************************************************
	// readback sequencer states
	// ************************************************************
	typedef enum logic [1:0]
	{
		TCP_ST_IDLE,
		TCP_ST_SHIFT,
		TCP_ST_TAIL
	} tcp_state_t;

endpackage

// file: core/tcp_sync.sv
// two-flop synchroniser for pins entering the ref_clk domain
// assumes async inputs, flops reset to zero
`timescale 1ns/1ns

module tcp_sync
	import tcp_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// pins in, synced levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

// file: core/tcp_port.sv
// three-wire configuration port with 16 latches and serial readback
// assumes pins are asynchronous to ref_clk; sources are ref_clk logic
//
// What this block does
// - 32-bit shift register feeding 16 latches
// - chip enable low silences the port
// - host sends MSB first, captured rising edge
// - load strobe rise copies word to one latch
// - low four bits select destination latch
// - each clock rise shifts readback bit, MSB first
// - extra edge after 16th bit releases line
// - frequency offset valid only during FSK demodulation
// - frequency offset is signed 16-bit word
// - level, filter gain, amplifier gain layout
// - battery, ADC, temperature in low seven bits
// - revision readable with nothing else programmed
// - revision word is four BCD digits
// - filter calibration low eight bits, upper zero
// - flag shows signal level has settled
`timescale 1ns/1ns
`include "tcp_regs.svh"

module tcp_port
	import tcp_pkg::*;
#(
	parameter logic [11:0] PRODUCT_CODE  = 12'h357, // arbitrary value
	parameter logic [3:0]  REVISION_CODE = 4'h2     // arbitrary value
)
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	// serial pins
	input  wire logic                 chip_enable,
	input  wire logic                 serial_clk,
	input  wire logic                 serial_write_line,
	input  wire logic                 load_strobe,
	output logic                      serial_read_line,
	output logic                      serial_read_oe,
	// measurement sources
	input  wire logic [15:0]          afc_value,
	input  wire logic                 fsk_rx_active,
	input  wire logic                 demod_lin_or_corr,
	input  wire logic [6:0]           rssi_level,
	input  wire logic [1:0]           filter_gain_field,
	input  wire logic [1:0]           amplifier_gain_field,
	input  wire logic [6:0]           battery_value,
	input  wire logic [6:0]           temp_value,
	input  wire logic [6:0]           adcin_value,
	input  wire logic [7:0]           filter_cal_value,
	input  wire logic                 level_settled_in,
	// status
	output logic                      level_settled_flag,
	output logic                      rb_busy,
	// local latch port
	input  wire logic [3:0]           cfg_addr,
	input  wire logic [31:0]          cfg_wdata,
	input  wire logic                 cfg_wr,
	input  wire logic                 cfg_rd,
	output logic      [31:0]          cfg_rdata
);

	// ************************************************************
	// pin synchronisation and edge detection
	// ************************************************************
	logic [3:0] pin_sync;
	logic       sclk_d_ff;
	logic       sle_d_ff;

	tcp_sync #(.WIDTH(4)) u_sync
	(
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in ({chip_enable, serial_clk, serial_write_line, load_strobe}),
		.sync_out (pin_sync)
	);

	wire ce_on     = pin_sync[3];
	wire sclk_s    = pin_sync[2];
	wire serial_write_line_s   = pin_sync[1];
	wire sle_s     = pin_sync[0];
	wire sclk_rise = ce_on & sclk_s & ~sclk_d_ff;
	wire sle_rise  = ce_on & sle_s & ~sle_d_ff;
	wire sle_fall  = ~sle_s & sle_d_ff;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_d_ff <= 1'b0;
			sle_d_ff  <= 1'b0;
		end
		else
		begin
			sclk_d_ff <= sclk_s;
			sle_d_ff  <= sle_s;
		end
	end

	// ************************************************************
	// shift register
	// ************************************************************
	tcp_state_t              state_ff;
	tcp_state_t              nxt_state;
	logic [`TCP_SR_W-1:0]    shift_ff;

	wire sr_idle  = (state_ff == TCP_ST_IDLE);
	wire sr_shift = sclk_rise & sr_idle;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			shift_ff <= '0;
		else if (sr_shift)
			shift_ff <= {shift_ff[`TCP_SR_W-2:0], serial_write_line_s};
	end

	// ************************************************************
	// latch bank
	// ************************************************************
	logic [`TCP_SR_W-1:0]      latch_ff [`TCP_NUM_LATCH];
	logic [`TCP_NUM_LATCH-1:0] lat_we;
	logic [`TCP_NUM_LATCH-1:0] lat_lw;

	wire [`TCP_SEL_W-1:0] sel      = shift_ff[`TCP_SEL_W-1:0];
	wire                  sle_load = sle_rise & sr_idle;

	genvar gi;
	generate
		for (gi = 0; gi < `TCP_NUM_LATCH; gi++)
		begin : g_latch
			assign lat_we[gi] = sle_load & (sel == `TCP_SEL_W'(gi));
			assign lat_lw[gi] = cfg_wr & (cfg_addr == `TCP_SEL_W'(gi));
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
					latch_ff[gi] <= `TCP_LATCH_RST;
				else if (lat_we[gi])
					latch_ff[gi] <= shift_ff;
				else if (lat_lw[gi])
					latch_ff[gi] <= cfg_wdata;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			cfg_rdata <= '0;
		else if (cfg_rd)
			cfg_rdata <= latch_ff[cfg_addr];
	end

	// ************************************************************
	// readback source selection
	// ************************************************************
	logic [`TCP_RB_W-1:0] rb_word;

	wire [3:0] rb_mode_raw = shift_ff[`TCP_RB_MODE_MSB:`TCP_RB_MODE_LSB];
	wire       rb_start    = sle_load & (sel == `TCP_RB_LATCH)
	                         & shift_ff[`TCP_RB_EN_BIT];
	wire       afc_ok      = fsk_rx_active & demod_lin_or_corr;

	always_comb
	begin
		rb_word = '0;
		unique case (rb_mode_raw)
			TCP_RB_AFC:     rb_word = afc_ok ? afc_value : '0;
			TCP_RB_RSSI:    rb_word = {5'h00, amplifier_gain_field,
			                           filter_gain_field, rssi_level};
			TCP_RB_BATTERY: rb_word = {9'h000, battery_value};
			TCP_RB_TEMP:    rb_word = {9'h000, temp_value};
			TCP_RB_ADCIN:   rb_word = {9'h000, adcin_value};
			TCP_RB_REV:     rb_word = {PRODUCT_CODE, REVISION_CODE};
			TCP_RB_FILTCAL: rb_word = {8'h00, filter_cal_value};
			default:        rb_word = '0;
		endcase
	end

	// ************************************************************
	// readback sequencer
	// ************************************************************
	logic [`TCP_RB_W-1:0] rb_shift_ff;
	logic [4:0]           bit_cnt_ff;

	wire last_edge = sclk_rise & (state_ff == TCP_ST_SHIFT) & (bit_cnt_ff == `TCP_RB_BITS);
	wire bit_edge  = sclk_rise & (state_ff == TCP_ST_SHIFT) & (bit_cnt_ff != `TCP_RB_BITS);
	wire rb_abort  = ~ce_on | sle_fall;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			TCP_ST_IDLE:  if (rb_start) nxt_state = TCP_ST_SHIFT;
			TCP_ST_SHIFT: if (rb_abort) nxt_state = TCP_ST_IDLE;
			              else if (last_edge) nxt_state = TCP_ST_TAIL;
			TCP_ST_TAIL:  if (rb_abort) nxt_state = TCP_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			state_ff <= TCP_ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rb_shift_ff <= '0;
			bit_cnt_ff  <= '0;
		end
		else if (rb_start)
		begin
			rb_shift_ff <= rb_word;
			bit_cnt_ff  <= '0;
		end
		else if (bit_edge)
		begin
			rb_shift_ff <= {rb_shift_ff[`TCP_RB_W-2:0], 1'b0};
			bit_cnt_ff  <= bit_cnt_ff + 5'h01;
		end
	end

	// ************************************************************
	// read line drive
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serial_read_oe   <= 1'b0;
			serial_read_line <= 1'b0;
		end
		else if (rb_abort || last_edge)
		begin
			serial_read_oe   <= 1'b0;
			serial_read_line <= 1'b0;
		end
		else if (rb_start)
		begin
			serial_read_oe   <= 1'b1;
			serial_read_line <= 1'b0;
		end
		else if (bit_edge)
			serial_read_line <= rb_shift_ff[`TCP_RB_W-1];
	end

	// ************************************************************
	// status
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			level_settled_flag <= 1'b0;
			rb_busy            <= 1'b0;
		end
		else
		begin
			level_settled_flag <= level_settled_in;
			rb_busy            <= (nxt_state != TCP_ST_IDLE);
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_rb_launch;
		rb_start;
	endsequence

	sequence s_first_bit;
		(state_ff == TCP_ST_SHIFT) && bit_edge && (bit_cnt_ff == 5'h00) && !rb_abort;
	endsequence

	a_ce_low_quiet: assert property (!ce_on |=> !serial_read_oe && sr_idle)
		else $error("read line driven while chip disabled");
	a_shift_msb_in: assert property (sr_shift |=> shift_ff[0] == $past(serial_write_line_s))
		else $error("serial bit not captured");
	a_latch_copy: assert property (sle_load |=> latch_ff[$past(sel)] == $past(shift_ff))
		else $error("latch did not take shifted word");
	a_one_latch: assert property ($onehot0(lat_we) && (sle_load == (|lat_we)))
		else $error("latch write count wrong");
	a_launch_drive: assert property (s_rb_launch |=> serial_read_oe ##0 !serial_read_line)
		else $error("readback not started with discarded bit");
	a_msb_first: assert property (s_rb_launch ##[1:64] s_first_bit
		|=> serial_read_line == $past(rb_shift_ff[15]))
		else $error("first readback bit is not MSB");
	a_tail_release: assert property (last_edge && ce_on && !sle_fall
		|=> !serial_read_oe ##0 state_ff == TCP_ST_TAIL)
		else $error("read line not released after sixteenth bit");
	a_idle_hiz: assert property (sr_idle |-> !serial_read_oe)
		else $error("read line driven outside readback");
	a_rev_word: assert property (rb_start && rb_mode_raw == TCP_RB_REV
		|=> rb_shift_ff == {PRODUCT_CODE, REVISION_CODE})
		else $error("revision word wrong");
	a_afc_gate: assert property (rb_start && rb_mode_raw == TCP_RB_AFC && !afc_ok
		|=> rb_shift_ff == 16'h0000)
		else $error("offset returned without FSK demodulation");
	a_filt_upper: assert property (rb_start && rb_mode_raw == TCP_RB_FILTCAL
		|=> rb_shift_ff[15:8] == 8'h00)
		else $error("filter calibration upper byte not zero");
	a_settled: assert property ($rose(level_settled_in) |=> level_settled_flag)
		else $error("settled flag late");

endmodule

// file: testbench/tcp_host_model.sv
// host model driving the three-wire serial pins of the port
// assumes ref_clk at 25 MHz; one serial clock period is eight ref_clk cycles
`timescale 1ns/1ns

module tcp_host_model
(
	// clock
	input  wire logic ref_clk,
	// serial pins
	output logic      chip_enable,
	output logic      serial_clk,
	output logic      serial_write_line,
	output logic      load_strobe,
	input  wire logic serial_read_line,
	input  wire logic serial_read_oe
);
	initial
	begin
		chip_enable = 1'b1;
		serial_clk = 1'b0;
		serial_write_line = 1'b0;
		load_strobe = 1'b0;
	end

	task automatic set_ce(input logic v);
		@(posedge ref_clk);
		chip_enable <= v;
	endtask

	// one serial clock; read pins sampled just before the rise
	task automatic tick(output logic rd, output logic oe);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rd = serial_read_line;
		oe = serial_read_oe;
		@(posedge ref_clk);
		serial_clk <= 1'b1;
		repeat (4) @(posedge ref_clk);
		serial_clk <= 1'b0;
	endtask

	// word out msb first, then strobe rise
	task automatic send(input logic [31:0] w, input logic keep);
		logic rd;
		logic oe;
		for (int i = 31; i >= 0; i--)
		begin
			serial_write_line <= w[i];
			tick(rd, oe);
		end
		serial_write_line <= ~w[0];
		repeat (4) @(posedge ref_clk);
		load_strobe <= 1'b1;
		repeat (8) @(posedge ref_clk);
		if (!keep)
			load_strobe <= 1'b0;
	endtask

	// readback request, n clocks with strobe held, then strobe low
	task automatic readback(input logic [3:0] m, input int n, output logic [15:0] d,
		output logic [17:0] oes);
		logic rd;
		d = 16'h0000;
		oes = 18'h00000;
		send({23'h000000, 1'b1, m, 4'h7}, 1'b1);
		for (int k = 0; k < n; k++)
		begin
			tick(rd, oes[k]);
			if (k >= 1 && k <= 16)
				d[16 - k] = rd;
		end
		repeat (4) @(posedge ref_clk);
		load_strobe <= 1'b0;
	endtask
endmodule

// file: testbench/tcp_port_tb.sv
// self-checking bench of the configuration and readback port
// assumes tcp_host_model drives the serial pins
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end

module tcp_port_tb;
	import tcp_pkg::*;
	logic        ref_clk, rst_b, chip_enable, serial_clk, serial_write_line, load_strobe;
	logic        serial_read_line, serial_read_oe, fsk_rx_active, demod_lin_or_corr;
	logic        level_settled_in, level_settled_flag, rb_busy, cfg_wr, cfg_rd;
	logic [15:0] afc_value, d;
	logic [17:0] oes;
	logic [6:0]  rssi_level, battery_value, temp_value, adcin_value;
	logic [1:0]  filter_gain_field, amplifier_gain_field;
	logic [7:0]  filter_cal_value;
	logic [3:0]  cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, r;
	int          errors, checks_done;

	tcp_port #(.PRODUCT_CODE(12'h468), .REVISION_CODE(4'h9)) i_dut (.ref_clk, .rst_b,
		.chip_enable, .serial_clk, .serial_write_line, .load_strobe, .serial_read_line,
		.serial_read_oe, .afc_value, .fsk_rx_active, .demod_lin_or_corr, .rssi_level,
		.filter_gain_field, .amplifier_gain_field, .battery_value, .temp_value,
		.adcin_value, .filter_cal_value, .level_settled_in, .level_settled_flag,
		.rb_busy, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata);
	tcp_host_model i_host (.ref_clk, .chip_enable, .serial_clk, .serial_write_line,
		.load_strobe, .serial_read_line, .serial_read_oe);

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic cfg_write(input logic [3:0] a, input logic [31:0] w);
		@(posedge ref_clk);
		cfg_addr <= a;
		cfg_wdata <= w;
		cfg_wr <= 1'b1;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
	endtask

	task automatic cfg_read(input logic [3:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		cfg_addr <= a;
		cfg_rd <= 1'b1;
		@(posedge ref_clk);
		cfg_rd <= 1'b0;
		@(negedge ref_clk);
		q = cfg_rdata;
	endtask

	function automatic logic [15:0] exp_rb(input logic [3:0] m);
		case (m)
			4'h0: exp_rb = (fsk_rx_active & demod_lin_or_corr) ? afc_value : 16'h0000;
			4'h1: exp_rb = {5'h00, amplifier_gain_field, filter_gain_field, rssi_level};
			4'h2: exp_rb = {9'h000, battery_value};
			4'h3: exp_rb = {9'h000, temp_value};
			4'h4: exp_rb = {9'h000, adcin_value};
			4'h5: exp_rb = 16'h4689;
			4'h6: exp_rb = {8'h00, filter_cal_value};
			default: exp_rb = 16'h0000;
		endcase
	endfunction

	// one readback, word and release timing judged, then idle state
	task automatic t_read(input logic [3:0] m);
		i_host.readback(m, 18, d, oes);
		`CHK(d, exp_rb(m))
		`CHK(oes, 18'h1FFFF)
		repeat (6) @(posedge ref_clk);
		`CHK(serial_read_oe, 1'b0)
		`CHK(rb_busy, 1'b0)
	endtask

	task automatic t_latches;
		logic [31:0] w;
		for (int i = 0; i < 16; i++)
		begin
			w = {16'hA5C3, 4'h0, ~i[3:0], 4'h6, i[3:0]};
			i_host.send(w, 1'b0);
			repeat (6) @(posedge ref_clk);
			cfg_read(i[3:0], r);
			`CHK(r, w)
		end
		$display("t_latches done");
	endtask

	task automatic t_ce_low;
		i_host.set_ce(1'b0);
		i_host.send(32'h0BAD_F002, 1'b0);
		i_host.set_ce(1'b1);
		repeat (6) @(posedge ref_clk);
		cfg_read(4'h2, r);
		`CHK(r, 32'hA5C3_0D62)
		$display("t_ce_low done");
	endtask

	task automatic t_abort_settle;
		i_host.readback(4'h1, 3, d, oes);
		@(negedge ref_clk);
		`CHK(rb_busy, 1'b1)
		repeat (6) @(posedge ref_clk);
		`CHK(serial_read_oe, 1'b0)
		`CHK(rb_busy, 1'b0)
		level_settled_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(level_settled_flag, 1'b1)
		level_settled_in <= 1'b0;
		cfg_write(4'hB, 32'h1234_5678);
		cfg_read(4'hB, r);
		`CHK(r, 32'h1234_5678)
		`CHK(level_settled_flag, 1'b0)
		$display("t_abort_settle done");
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#2000000;
		errors++;
		test_done();
	end

	initial
	begin
		rst_b = 1'b0;
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata, level_settled_in} = '0;
		{afc_value, fsk_rx_active, demod_lin_or_corr} = {16'h8F31, 2'b11};
		{rssi_level, filter_gain_field, amplifier_gain_field} = {7'h5A, 2'h2, 2'h1};
		{battery_value, temp_value, adcin_value, filter_cal_value} = 29'h0CD3_2CB7;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		`CHK(serial_read_oe, 1'b0)
		t_read(4'h5);
		$display("t_revision done");
		t_latches();
		t_ce_low();
		for (int m = 0; m < 8; m++)
			t_read(m[3:0]);
		fsk_rx_active <= 1'b0;
		t_read(4'h0);
		$display("t_modes done");
		t_abort_settle();
		test_done();
	end
endmodule
